// ==== src/rx_status_pkg.sv ====
// constants shared by the receive status, slot and clock check logic
// assumes a 32-bit AHB-Lite register bus and one system clock
package rx_status_pkg;
	localparam logic [7:0] OFF_STATUS = 8'h80;
	localparam logic [7:0] OFF_SLOT = 8'h84;
	localparam logic [7:0] OFF_CLKCHK = 8'h88;
	localparam logic [7:0] OFF_IRQ_ENABLE = 8'h90;
	localparam logic [7:0] OFF_FRAME_CFG = 8'h94;

	localparam int BIT_OVERRUN = 0;
	localparam int BIT_EARLY_SYNC = 1;
	localparam int BIT_CLOCK_FAIL = 2;
	localparam int BIT_DMA_ERROR = 7;
	localparam int BIT_ANY_ERROR = 8;

	localparam int CNT_LSB = 24;
	localparam int MAX_LSB = 16;
	localparam int MIN_LSB = 8;
	localparam int PS_LSB = 0;

	localparam logic [7:0] RESET_BOUND = 8'h00;
	localparam logic [3:0] RESET_PRESCALE = 4'h0;
	localparam logic [9:0] RESET_LAST_SLOT = 10'h000;
	localparam logic [31:0] RESET_WORD = 32'h0000_0000;

	localparam int WINDOW_EDGES = 32;
	localparam logic [9:0] SLOT_MAX = 10'h17f;
	localparam logic [3:0] PRESCALE_MAX = 4'h8;
	localparam logic [7:0] COUNT_SAT = 8'hff;

	typedef enum logic [1:0] {
		BUS_IDLE,
		BUS_WRITE,
		BUS_READ
	} bus_phase_t;
endpackage

// ==== src/rx_clock_checker.sv ====
// receive clock failure detector: prescaled system clocks per window
// assumes masterClk is a level already synchronous to clk
`timescale 1ns/1ns
module rx_clock_checker
	import rx_status_pkg::*;
(
	input wire logic clk,
	input wire logic sys_rst,
	input wire logic masterClk,
	input wire logic [3:0] prescaler,
	input wire logic [7:0] lowerBound,
	input wire logic [7:0] upperBound,
	output logic [7:0] measuredCount,
	output logic clockFail
);
	logic masterPrev;
	logic [7:0] preCount;
	logic [7:0] tickCount;
	logic [5:0] edgeCount;
	logic masterRise;
	logic preTick;
	logic windowEnd;

	function automatic logic [7:0] prescaleMask(input logic [3:0] code);
		logic [3:0] n;
		n = (code > PRESCALE_MAX) ? PRESCALE_MAX : code;
		prescaleMask = 8'((9'h001 << n) - 9'h001);
	endfunction

	assign masterRise = masterClk & ~masterPrev;
	assign preTick = (preCount & prescaleMask(prescaler))
		== prescaleMask(prescaler);
	assign windowEnd = masterRise && (edgeCount == 6'(WINDOW_EDGES - 1));

	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			masterPrev <= 1'b0;
		end else begin
			masterPrev <= masterClk;
		end
	end

	// free divider, the mask picks 2^n
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			preCount <= 8'h00;
		end else begin
			preCount <= preCount + 8'h01;
		end
	end

	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			edgeCount <= 6'h00;
			tickCount <= 8'h00;
		end else begin
			if (windowEnd) begin
				edgeCount <= 6'h00;
				tickCount <= 8'h00;
			end else begin
				if (masterRise) begin
					edgeCount <= edgeCount + 6'h01;
				end
				if (preTick && tickCount != COUNT_SAT) begin
					tickCount <= tickCount + 8'h01;
				end
			end
		end
	end

	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			measuredCount <= RESET_BOUND;
			clockFail <= 1'b0;
		end else begin
			clockFail <= windowEnd && (tickCount < lowerBound
				|| tickCount > upperBound);
			if (windowEnd) begin
				measuredCount <= tickCount;
			end
		end
	end
endmodule

// ==== src/rx_slot_tracker.sv ====
// current receive slot counter and early frame sync detection
// assumes frameSync and slotTick are one-cycle pulses on clk
`timescale 1ns/1ns
module rx_slot_tracker
	import rx_status_pkg::*;
(
	input wire logic clk,
	input wire logic sys_rst,
	input wire logic frameSync,
	input wire logic slotTick,
	input wire logic [9:0] lastSlot,
	output logic [9:0] currentSlot,
	output logic earlySync
);
	logic inFrame;
	logic [9:0] limit;

	assign limit = (lastSlot > SLOT_MAX) ? SLOT_MAX : lastSlot;

	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			currentSlot <= 10'h000;
			inFrame <= 1'b0;
		end else if (frameSync) begin
			currentSlot <= 10'h000;
			inFrame <= 1'b1;
		end else if (slotTick) begin
			// wraps at the frame end, never above 383
			if (currentSlot >= limit) begin
				currentSlot <= 10'h000;
			end else begin
				currentSlot <= currentSlot + 10'h001;
			end
		end
	end

	// sync before the last slot of a running frame
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			earlySync <= 1'b0;
		end else begin
			earlySync <= frameSync && inFrame && currentSlot != limit;
		end
	end
endmodule

// ==== src/rx_status_slot_clock_check.sv ====
// receive status flags, slot register and clock check control over AHB-Lite
// assumes one system clock; event inputs are one-cycle pulses on clk
`timescale 1ns/1ns
module rx_status_slot_clock_check
	import rx_status_pkg::*;
(
	input wire logic clk,
	input wire logic sys_rst,
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic hreadyout,
	output logic hresp,
	output logic [31:0] hrdata,
	input wire logic rxHighFreqMasterClock,
	input wire logic rxFrameSync,
	input wire logic rxSlotTick,
	input wire logic shiftToBuffer,
	input wire logic bufferRead,
	input wire logic rxDmaErrorEvent,
	output logic rxInterrupt,
	output logic [9:0] rxCurrentSlotField,
	output logic bufferFull
);
	bus_phase_t phase;
	logic [7:0] phaseAddr;
	logic rxOverrunFlag;
	logic rxEarlySyncFlag;
	logic rxClockFailFlag;
	logic rxDmaErrorFlag;
	logic [31:0] rxInterruptEnables;
	logic [7:0] rxCountLowerBound;
	logic [7:0] rxCountUpperBound;
	logic [3:0] rxCheckPrescaler;
	logic [9:0] frameLastSlot;
	logic [7:0] rxMeasuredCount;
	logic clockFailEvent;
	logic earlySyncEvent;
	logic overrunEvent;
	logic [9:0] currentSlot;
	logic addrTaken;
	logic wrEn;
	logic [31:0] statusWord;
	logic [31:0] next_hrdata;

	function automatic logic clearHit(input logic en, input logic [7:0] a,
		input logic [31:0] d, input int b);
		clearHit = en && a == OFF_STATUS && d[b];
	endfunction

	function automatic logic nextFlag(input logic cur, input logic set,
		input logic clr);
		// set wins over a clear in the same cycle
		nextFlag = set | (cur & ~clr);
	endfunction

	rx_clock_checker i_rx_clock_checker (
		.clk(clk),
		.sys_rst(sys_rst),
		.masterClk(rxHighFreqMasterClock),
		.prescaler(rxCheckPrescaler),
		.lowerBound(rxCountLowerBound),
		.upperBound(rxCountUpperBound),
		.measuredCount(rxMeasuredCount),
		.clockFail(clockFailEvent)
	);

	rx_slot_tracker slots (
		.clk(clk),
		.sys_rst(sys_rst),
		.frameSync(rxFrameSync),
		.slotTick(rxSlotTick),
		.lastSlot(frameLastSlot),
		.currentSlot(currentSlot),
		.earlySync(earlySyncEvent)
	);

	assign addrTaken = hsel && hready && htrans[1];
	assign wrEn = (phase == BUS_WRITE);
	assign overrunEvent = shiftToBuffer && bufferFull && !bufferRead;

	always_comb begin
		statusWord = RESET_WORD;
		statusWord[BIT_OVERRUN] = rxOverrunFlag;
		statusWord[BIT_EARLY_SYNC] = rxEarlySyncFlag;
		statusWord[BIT_CLOCK_FAIL] = rxClockFailFlag;
		statusWord[BIT_DMA_ERROR] = rxDmaErrorFlag;
		statusWord[BIT_ANY_ERROR] = rxOverrunFlag | rxEarlySyncFlag
			| rxClockFailFlag | rxDmaErrorFlag;
	end

	always_comb begin
		next_hrdata = RESET_WORD;
		case (haddr[7:0])
			OFF_STATUS: begin
				next_hrdata = statusWord;
			end
			OFF_SLOT: begin
				next_hrdata = {22'h00_0000, currentSlot};
			end
			OFF_CLKCHK: begin
				next_hrdata[CNT_LSB +: 8] = rxMeasuredCount;
				next_hrdata[MAX_LSB +: 8] = rxCountUpperBound;
				next_hrdata[MIN_LSB +: 8] = rxCountLowerBound;
				next_hrdata[PS_LSB +: 4] = rxCheckPrescaler;
			end
			OFF_IRQ_ENABLE: begin
				next_hrdata = rxInterruptEnables;
			end
			OFF_FRAME_CFG: begin
				next_hrdata = {22'h00_0000, frameLastSlot};
			end
			default: begin
				next_hrdata = RESET_WORD;
			end
		endcase
	end

	// bus phase tracking, zero wait states
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			phase <= BUS_IDLE;
			phaseAddr <= 8'h00;
		end else if (hready) begin
			if (addrTaken) begin
				phase <= hwrite ? BUS_WRITE : BUS_READ;
				phaseAddr <= haddr[7:0];
			end else begin
				phase <= BUS_IDLE;
			end
		end
	end

	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			hreadyout <= 1'b0;
			hresp <= 1'b0;
			hrdata <= RESET_WORD;
		end else begin
			hreadyout <= 1'b1;
			hresp <= 1'b0;
			if (addrTaken && !hwrite) begin
				hrdata <= next_hrdata;
			end
		end
	end

	// software-written configuration
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			rxCountLowerBound <= RESET_BOUND;
			rxCountUpperBound <= RESET_BOUND;
			rxCheckPrescaler <= RESET_PRESCALE;
		end else if (wrEn && phaseAddr == OFF_CLKCHK) begin
			rxCountUpperBound <= hwdata[MAX_LSB +: 8];
			rxCountLowerBound <= hwdata[MIN_LSB +: 8];
			rxCheckPrescaler <= hwdata[PS_LSB +: 4];
		end
	end

	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			rxInterruptEnables <= RESET_WORD;
			frameLastSlot <= RESET_LAST_SLOT;
		end else if (wrEn) begin
			if (phaseAddr == OFF_IRQ_ENABLE) begin
				rxInterruptEnables <= RESET_WORD;
				rxInterruptEnables[BIT_OVERRUN] <= hwdata[BIT_OVERRUN];
				rxInterruptEnables[BIT_EARLY_SYNC] <= hwdata[BIT_EARLY_SYNC];
				rxInterruptEnables[BIT_CLOCK_FAIL] <= hwdata[BIT_CLOCK_FAIL];
				rxInterruptEnables[BIT_DMA_ERROR] <= hwdata[BIT_DMA_ERROR];
			end
			if (phaseAddr == OFF_FRAME_CFG) begin
				frameLastSlot <= hwdata[9:0];
			end
		end
	end

	// holding buffer occupancy for overrun detection
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			bufferFull <= 1'b0;
		end else if (shiftToBuffer) begin
			bufferFull <= 1'b1;
		end else if (bufferRead) begin
			bufferFull <= 1'b0;
		end
	end

	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			rxOverrunFlag <= 1'b0;
			rxEarlySyncFlag <= 1'b0;
			rxClockFailFlag <= 1'b0;
			rxDmaErrorFlag <= 1'b0;
		end else begin
			rxOverrunFlag <= nextFlag(rxOverrunFlag, overrunEvent,
				clearHit(wrEn, phaseAddr, hwdata, BIT_OVERRUN));
			rxEarlySyncFlag <= nextFlag(rxEarlySyncFlag, earlySyncEvent,
				clearHit(wrEn, phaseAddr, hwdata, BIT_EARLY_SYNC));
			rxClockFailFlag <= nextFlag(rxClockFailFlag, clockFailEvent,
				clearHit(wrEn, phaseAddr, hwdata, BIT_CLOCK_FAIL));
			rxDmaErrorFlag <= nextFlag(rxDmaErrorFlag, rxDmaErrorEvent,
				clearHit(wrEn, phaseAddr, hwdata, BIT_DMA_ERROR));
		end
	end

	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			rxInterrupt <= 1'b0;
			rxCurrentSlotField <= 10'h000;
		end else begin
			rxInterrupt <= |(statusWord[BIT_DMA_ERROR:0]
				& rxInterruptEnables[BIT_DMA_ERROR:0]);
			rxCurrentSlotField <= currentSlot;
		end
	end
endmodule

// ==== sim/rx_status_slot_clock_check_asserts.sv ====
// checker for the receive status register bank, bound to its top module
// assumes hready is tied to hreadyout on a single-slave bus
`timescale 1ns/1ns
module rx_status_slot_clock_check_asserts
	import rx_status_pkg::*;
(
	input wire logic clk,
	input wire logic sys_rst,
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic hready,
	input wire logic hreadyout,
	input wire logic hresp,
	input wire logic [31:0] hrdata,
	input wire logic rxFrameSync,
	input wire logic rxSlotTick,
	input wire logic shiftToBuffer,
	input wire logic bufferRead,
	input wire logic rxInterrupt,
	input wire logic [9:0] rxCurrentSlotField,
	input wire logic bufferFull
);
	logic rdTake;
	assign rdTake = hsel && hready && htrans[1] && !hwrite;
	default clocking @(posedge clk); endclocking
	default disable iff (sys_rst);
	resp_okay_a: assert property (hresp == 1'b0)
		else $error("bus response not okay");
	ready_up_a: assert property (!$past(sys_rst) |-> hreadyout)
		else $error("ready low outside reset");
	slot_range_a: assert property (
		rxCurrentSlotField <= SLOT_MAX) else $error("slot above limit");
	sync_zero_a: assert property (
		rxFrameSync |-> ##2 rxCurrentSlotField == 10'h000)
		else $error("frame sync did not zero slot");
	slot_moves_a: assert property (
		$changed(rxCurrentSlotField) |->
		$past(rxSlotTick, 2) || $past(rxFrameSync, 2))
		else $error("slot moved without cause");
	buffer_fill_a: assert property (
		shiftToBuffer |=> bufferFull) else $error("buffer not full");
	buffer_drain_a: assert property (
		bufferRead && !shiftToBuffer |=> !bufferFull)
		else $error("buffer not drained");
	hrdata_hold_a: assert property (
		!$past(rdTake) |-> $stable(hrdata)) else $error("read data moved");
	slot_rsvd_a: assert property (
		rdTake && haddr[7:0] == OFF_SLOT |=> hrdata[31:10] == 22'h00_0000)
		else $error("slot upper bits not zero");
	chk_rsvd_a: assert property (
		rdTake && haddr[7:0] == OFF_CLKCHK |=> hrdata[7:4] == 4'h0)
		else $error("check control bits 7-4 not zero");
	err_or_a: assert property (
		rdTake && haddr[7:0] == OFF_STATUS |=>
		hrdata[8] == (hrdata[7] | hrdata[2] | hrdata[1] | hrdata[0]))
		else $error("summary error bit wrong");
	cover property (rxInterrupt);
	cover property (rdTake && haddr[7:0] == OFF_SLOT);
	cover property ($fell(bufferFull));
endmodule

bind rx_status_slot_clock_check rx_status_slot_clock_check_asserts i_chk(
	.clk(clk), .sys_rst(sys_rst), .hsel(hsel), .haddr(haddr),
	.htrans(htrans), .hwrite(hwrite), .hready(hready),
	.hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
	.rxFrameSync(rxFrameSync), .rxSlotTick(rxSlotTick),
	.shiftToBuffer(shiftToBuffer), .bufferRead(bufferRead),
	.rxInterrupt(rxInterrupt), .rxCurrentSlotField(rxCurrentSlotField),
	.bufferFull(bufferFull));

// ==== sim/rx_status_slot_clock_check_tb.sv ====
// self-checking bench for the receive status register bank
// assumes a lone AHB-Lite slave, hready looped back from hreadyout
`timescale 1ns/1ns
module rx_status_slot_clock_check_tb;
	import rx_status_pkg::*;
	logic clk, sys_rst, hsel, hwrite, hreadyout, hresp, mclk, irq, full, f;
	logic [31:0] haddr, hwdata, hrdata, rd, d;
	logic [1:0] htrans;
	logic [4:0] evs;
	logic [9:0] slotField;
	logic [23:0] c;
	logic [23:0] cfgs [4] = '{24'hc0_4000, 24'h08_0002, 24'h30_1002,
		24'hff_0208};
	int error_cnt, checks_done, n, t;
	rx_status_slot_clock_check i_rx_status_slot_clock_check(
		.clk(clk), .sys_rst(sys_rst), .hsel(hsel), .haddr(haddr),
		.htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata),
		.hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp),
		.hrdata(hrdata), .rxHighFreqMasterClock(mclk),
		.rxFrameSync(evs[0]), .rxSlotTick(evs[1]), .shiftToBuffer(evs[2]),
		.bufferRead(evs[3]), .rxDmaErrorEvent(evs[4]), .rxInterrupt(irq),
		.rxCurrentSlotField(slotField), .bufferFull(full));
	initial begin
		clk = 0;
		forever #50 clk = ~clk;
	end
	function automatic logic expFail(logic [7:0] lo, hi, logic [3:0] ps);
		int k = 128 >> ps;
		return (k < lo) || (k > hi);
	endfunction
	function automatic logic near(logic [7:0] a, logic [7:0] b);
		return (int'(a) + 6 >= int'(b)) && (int'(a) <= int'(b) + 6);
	endfunction
	task wrap_up;
		$display("checks %0d errors %0d", checks_done, error_cnt);
		if (error_cnt == 0 && checks_done > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask
	task check(input logic [31:0] seen, input logic [31:0] exp);
		checks_done++;
		if (seen !== exp) begin
			error_cnt++;
			$display("wrong value at %0t: got %h want %h", $time, seen, exp);
		end
	endtask
	task waitReady;
		n = 0;
		do begin
			@(posedge clk);
			n++;
		end while (hreadyout !== 1'b1 && n < 20);
		if (hreadyout !== 1'b1) begin
			error_cnt++;
			wrap_up;
		end
	endtask
	task bus(input logic [7:0] a, input logic w, input logic [31:0] wd);
		@(posedge clk);
		hsel <= 1;
		haddr <= 32'(a);
		hwrite <= w;
		htrans <= 2'h2;
		waitReady;
		htrans <= 2'h0;
		hsel <= 0;
		hwdata <= wd;
		waitReady;
		rd = hrdata;
	endtask
	task wr(input logic [7:0] a, input logic [31:0] wd);
		bus(a, 1'b1, wd);
	endtask
	task rdChk(input logic [7:0] a, input logic [31:0] e);
		bus(a, 1'b0, 32'h0000_0000);
		check(rd, e);
	endtask
	task pulse(input logic [4:0] v);
		@(posedge clk);
		evs <= v;
		@(posedge clk);
		evs <= 5'h00;
	endtask
	task mrun(input int k);
		repeat (k) begin
			@(posedge clk);
			mclk <= 1;
			repeat (2) @(posedge clk);
			mclk <= 0;
			@(posedge clk);
		end
	endtask
	initial begin
		repeat (60000) @(posedge clk);
		error_cnt++;
		wrap_up;
	end
	initial begin
		sys_rst = 1; hsel = 0; haddr = 0; htrans = 0; hwrite = 0;
		hwdata = 0; evs = 0; mclk = 0; error_cnt = 0; checks_done = 0;
		void'($urandom(42));
		repeat (10) @(posedge clk);
		sys_rst <= 0;
		rdChk(OFF_CLKCHK, 32'h0000_0000);
		rdChk(OFF_STATUS, 32'h0000_0000);
		rdChk(OFF_SLOT, 32'h0000_0000);
		d = $urandom;
		wr(OFF_CLKCHK, d);
		rdChk(OFF_CLKCHK, d & 32'h00ff_ff0f);
		wr(OFF_SLOT, 32'hffff_ffff);
		rdChk(OFF_SLOT, 32'h0000_0000);
		rdChk(8'h9c, 32'h0000_0000);
		wr(OFF_FRAME_CFG, 32'h0000_017f);
		rdChk(OFF_FRAME_CFG, 32'h0000_017f);
		pulse(5'h01);
		t = $urandom_range(383, 300);
		repeat (t) pulse(5'h02);
		rdChk(OFF_SLOT, 32'(t));
		check({22'h0, slotField}, 32'(t));
		repeat (383 - t) pulse(5'h02);
		rdChk(OFF_SLOT, 32'h0000_017f);
		check({22'h0, slotField}, 32'h0000_017f);
		pulse(5'h02);
		rdChk(OFF_SLOT, 32'h0000_0000);
		pulse(5'h01);
		repeat (4) @(posedge clk);
		rdChk(OFF_STATUS, 32'h0000_0102);
		wr(OFF_STATUS, 32'h0000_0000);
		rdChk(OFF_STATUS, 32'h0000_0102);
		wr(OFF_STATUS, 32'h0000_0002);
		rdChk(OFF_STATUS, 32'h0000_0000);
		repeat (383) pulse(5'h02);
		pulse(5'h01);
		repeat (4) @(posedge clk);
		rdChk(OFF_STATUS, 32'h0000_0000);
		wr(OFF_IRQ_ENABLE, 32'hffff_ffff);
		rdChk(OFF_IRQ_ENABLE, 32'h0000_0087);
		pulse(5'h04);
		pulse(5'h04);
		repeat (4) @(posedge clk);
		check({31'h0, irq}, 32'h1);
		check({31'h0, full}, 32'h1);
		rdChk(OFF_STATUS, 32'h0000_0101);
		wr(OFF_IRQ_ENABLE, 32'h0000_0000);
		repeat (2) @(posedge clk);
		check({31'h0, irq}, 32'h0);
		wr(OFF_IRQ_ENABLE, 32'h0000_0087);
		wr(OFF_STATUS, 32'h0000_0001);
		pulse(5'h08);
		pulse(5'h10);
		repeat (4) @(posedge clk);
		rdChk(OFF_STATUS, 32'h0000_0180);
		check({31'h0, full}, 32'h0);
		// dma event sampled on the clearing edge
		fork
			wr(OFF_STATUS, 32'h0000_0080);
			begin
				repeat (2) @(posedge clk);
				evs <= 5'h10;
				@(posedge clk);
				evs <= 5'h00;
			end
		join
		rdChk(OFF_STATUS, 32'h0000_0180);
		wr(OFF_STATUS, 32'h0000_0080);
		rdChk(OFF_STATUS, 32'h0000_0000);
		for (int i = 0; i < 4; i++) begin
			c = cfgs[i];
			f = expFail(c[15:8], c[23:16], c[3:0]);
			wr(OFF_CLKCHK, {8'hff, c});
			mrun(40);
			wr(OFF_STATUS, 32'h0000_0004);
			mrun(40);
			rdChk(OFF_STATUS, {23'h0, f, 5'h0, f, 2'h0});
			check({31'h0, irq}, {31'h0, f});
			bus(OFF_CLKCHK, 1'b0, 32'h0000_0000);
			check({31'h0, near(rd[31:24], 8'(128 >> c[3:0]))}, 32'h1);
		end
		wrap_up;
	end
endmodule
